// file: rtl/track_check_map.svh
// Constants of the tracking check leaf: leaf code, return codes, page types,
// fault and exit encodings and register offsets.
// Assumes inclusion by its bare name from the design files.
`ifndef TRACK_CHECK_MAP_SVH
`define TRACK_CHECK_MAP_SVH

// ****************************************************************
// Leaf selection and feature report
// ****************************************************************
`define TC_LEAF_CODE 32'h0000_0011
`define TC_FEATURE_BIT 6
`define TC_CPL_SUPERVISOR 2'h0
`define TC_PAGE_OFFSET_BITS 12

// ****************************************************************
// Return codes in the accumulator
// ****************************************************************
`define TC_RET_OK 64'h0000_0000_0000_0000
`define TC_RET_PAGE_CONFLICT 64'h0000_0000_0000_0007
`define TC_RET_PAGE_INVALID 64'h0000_0000_0000_0006
`define TC_RET_PREV_INCOMPLETE 64'h0000_0000_0000_0011
`define TC_RET_NOT_NEEDED 64'h0000_0000_0000_001b

// ****************************************************************
// Page type codes (plain defaults)
// ****************************************************************
`define TC_PT_CONTROL 8'h00
`define TC_PT_REGULAR 8'h01
`define TC_PT_THREAD_CTRL 8'h02
`define TC_PT_TRIMMED 8'h03
`define TC_SHADOW_STACK_FIRST_TYPE 8'h04
`define TC_SHADOW_STACK_REST_TYPE 8'h05

// ****************************************************************
// Fault and exit encodings (plain defaults)
// ****************************************************************
`define TC_PF_ENCLAVE_BIT 15
`define TC_EXIT_REASON 16'h0001
`define TC_QUAL_RESOURCE 8'h01
`define TC_QUAL_REFERENCE 8'h02

// ****************************************************************
// Register offsets and reset values
// ****************************************************************
`define TC_REG_CTRL 8'h00
`define TC_REG_STATUS 8'h04
`define TC_REG_IRQ_EN 8'h08
`define TC_REG_IRQ_CLR 8'h0c
`define TC_REG_LAST_RET 8'h10
`define TC_REG_FEATURE 8'h14
`define TC_CTRL_RESET 1'h1
`define TC_IRQ_EN_RESET 3'h0
`define TC_EV_DONE 0
`define TC_EV_FAULT 1
`define TC_EV_EXIT 2

`endif

// file: rtl/track_check_pkg.sv
// Types shared by the tracking check leaf.
// Assumes the constants header is included before use.
package track_check_pkg;

  // ****************************************************************
  // Outcome of one evaluation
  // ****************************************************************
  typedef enum logic [2:0] {
    OUT_NONE,
    OUT_INV_OP,
    OUT_GP,
    OUT_PF,
    OUT_EXIT,
    OUT_DONE
  } outcome_t;

endpackage

// file: rtl/track_check_leaf.sv
// Execution logic of the thread-safe tracking check leaf, with a small
// register port for control, event status and interrupt.
// Assumes page lookup answers (residency, map entry, busy and pending
// state) are presented by the core beside the request in the same cycle.
//
// Function
// - Execute only when leaf code 11H is issued; report support in feature bit 6.
// - Accept the leaf only at privilege level zero; software issues it there.
// - Page address not 4KByte aligned raises general protection fault, code zero.
// - Address outside protected page cache raises page fault with enclave bit.
// - Page under modification gives ZF=1, CF=0, code 7.
// - Invalid map entry gives ZF=1, CF=0, code 6.
// - Owner found via map entry for data pages; control page used directly.
// - Any other page type gives ZF=0, CF=1, code 27.
// - Tracking conflict without exit gives ZF=1, CF=0, code 7.
// - Non-root with virtualisation control raises conflict exit with set fields.
// - Nonzero pending tracking gives ZF=1, CF=0, code 17 unless exit.
// - ZF only on failures, CF only not-needed; success clears both, returns zero.
// - Every non-faulting completion clears parity, adjust, overflow and sign flags.
// - Protected mode segment violation or unusable segment raises fault code zero.
// - Noncanonical address in 64-bit mode raises general protection fault, code zero.
// - Target shared, control page exclusive only against tracking leaves.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "track_check_map.svh"

module track_check_leaf #(
  parameter int ADDR_W = 64,
  parameter int REG_AW = 8
) (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // Leaf request
  input wire logic I_REQ,
  input wire logic [31:0] I_EAX,
  input wire logic [ADDR_W-1:0] I_RCX,
  input wire logic [1:0] I_CPL,
  input wire logic I_PROT_MODE,
  input wire logic I_LONG_MODE,
  input wire logic I_SEG_VIOLATION,
  input wire logic I_SEG_UNUSABLE,
  input wire logic I_VMX_NONROOT,
  input wire logic I_EPC_VIRT_EN,
  // Page lookup answers
  input wire logic I_IN_PAGE_CACHE,
  input wire logic I_PAGE_MODIFYING,
  input wire logic I_MAP_VALID,
  input wire logic [7:0] I_MAP_TYPE,
  input wire logic [ADDR_W-1:0] I_MAP_OWNER,
  input wire logic I_TRACK_IN_USE,
  input wire logic [63:0] I_TRACK_PENDING,
  input wire logic [63:0] I_ENCLAVE_CONTEXT,
  // Register port
  input wire logic [REG_AW-1:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [31:0] O_REG_RDATA,
  // Result
  output logic O_DONE,
  output logic [63:0] O_RAX,
  output logic O_ZF,
  output logic O_CF,
  output logic O_ARITH_CLR,
  output logic [ADDR_W-1:0] O_CTRL_PAGE,
  output logic O_TRACK_LOCK,
  // Faults and exit
  output logic O_INV_OP,
  output logic O_GP_FAULT,
  output logic O_PG_FAULT,
  output logic [31:0] O_PF_CODE,
  output logic O_VM_EXIT,
  output logic [15:0] O_EXIT_REASON,
  output logic [7:0] O_EXIT_QUAL,
  output logic [31:0] O_EXIT_ERROR,
  output logic [63:0] O_EXIT_GPA,
  output logic [ADDR_W-1:0] O_EXIT_GLA,
  // Interrupt
  output logic O_IRQ
);

  // Refused at elaboration: the canonical check needs bit 47 or a narrower bus
  if (ADDR_W < 32 || ADDR_W > 64)
  begin : g_bad_addr_w
    $error("ADDR_W must lie between 32 and 64");
  end
  // Offsets up to the feature word need five address bits
  if (REG_AW < 5)
  begin : g_bad_reg_aw
    $error("REG_AW too small for the register map");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic done;
    logic [63:0] rax;
    logic zf;
    logic cf;
    logic arith_clr;
    logic [ADDR_W-1:0] ctrl_page;
    logic track_lock;
    logic inv_op;
    logic gp;
    logic pf;
    logic [31:0] pf_code;
    logic vm_exit;
    logic [7:0] exit_qual;
    logic [63:0] exit_gpa;
    logic leaf_en;
    logic [2:0] status;
    logic [2:0] irq_en;
    logic [31:0] rdata;
  } state_t;

  state_t st_q;
  state_t st_d;

  // Canonical when all bits above bit 47 repeat bit 47
  function automatic logic is_canonical(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] ext;
    ext = '0;
    if (ADDR_W <= 48)
      return 1'b1;
    ext = a >> 47;
    return (ext == '0) || (ext == ({ADDR_W{1'b1}} >> 47));
  endfunction

  function automatic logic is_data_type(input logic [7:0] t);
    return (t == `TC_PT_REGULAR) || (t == `TC_PT_THREAD_CTRL) ||
      (t == `TC_PT_TRIMMED) || (t == `TC_SHADOW_STACK_FIRST_TYPE) || (t == `TC_SHADOW_STACK_REST_TYPE);
  endfunction

  logic leaf_hit;
  logic virt_exit;
  logic [ADDR_W-1:0] owner;
  track_check_pkg::outcome_t outcome;
  logic [2:0] events;

  assign leaf_hit = I_REQ && st_q.leaf_en && (I_EAX == `TC_LEAF_CODE);
  assign virt_exit = I_VMX_NONROOT && I_EPC_VIRT_EN;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_d = st_q;
    owner = '0;
    outcome = track_check_pkg::OUT_NONE;
    st_d.done = 1'b0;
    st_d.arith_clr = 1'b0;
    st_d.track_lock = 1'b0;
    st_d.inv_op = 1'b0;
    st_d.gp = 1'b0;
    st_d.pf = 1'b0;
    st_d.vm_exit = 1'b0;
    st_d.rdata = '0;
    // Checks chained so that the first failure alone decides
    if (leaf_hit)
    begin
      if (I_CPL != `TC_CPL_SUPERVISOR)
        outcome = track_check_pkg::OUT_INV_OP;
      else if (I_PROT_MODE && (I_SEG_VIOLATION || I_SEG_UNUSABLE))
        outcome = track_check_pkg::OUT_GP;
      else if (I_LONG_MODE && !is_canonical(I_RCX))
        outcome = track_check_pkg::OUT_GP;
      else if (I_RCX[`TC_PAGE_OFFSET_BITS-1:0] != '0)
        outcome = track_check_pkg::OUT_GP;
      else if (!I_IN_PAGE_CACHE)
        outcome = track_check_pkg::OUT_PF;
      else if (I_PAGE_MODIFYING)
      begin
        outcome = track_check_pkg::OUT_DONE;
        st_d.rax = `TC_RET_PAGE_CONFLICT;
      end
      else if (!I_MAP_VALID)
      begin
        outcome = track_check_pkg::OUT_DONE;
        st_d.rax = `TC_RET_PAGE_INVALID;
      end
      else if (!is_data_type(I_MAP_TYPE) && I_MAP_TYPE != `TC_PT_CONTROL)
      begin
        outcome = track_check_pkg::OUT_DONE;
        st_d.rax = `TC_RET_NOT_NEEDED;
      end
      else
      begin
        owner = is_data_type(I_MAP_TYPE) ? I_MAP_OWNER : I_RCX;
        st_d.ctrl_page = owner;
        if (I_TRACK_IN_USE)
        begin
          if (virt_exit)
          begin
            outcome = track_check_pkg::OUT_EXIT;
            st_d.exit_qual = `TC_QUAL_RESOURCE;
          end
          else
          begin
            outcome = track_check_pkg::OUT_DONE;
            st_d.rax = `TC_RET_PAGE_CONFLICT;
          end
        end
        else if (I_TRACK_PENDING != 64'h0)
        begin
          if (virt_exit)
          begin
            outcome = track_check_pkg::OUT_EXIT;
            st_d.exit_qual = `TC_QUAL_REFERENCE;
          end
          else
          begin
            outcome = track_check_pkg::OUT_DONE;
            st_d.rax = `TC_RET_PREV_INCOMPLETE;
          end
        end
        else
        begin
          outcome = track_check_pkg::OUT_DONE;
          st_d.rax = `TC_RET_OK;
          st_d.track_lock = 1'b1;
        end
      end
    end
    case (outcome)
      track_check_pkg::OUT_INV_OP: st_d.inv_op = 1'b1;
      track_check_pkg::OUT_GP: st_d.gp = 1'b1;
      track_check_pkg::OUT_PF:
      begin
        st_d.pf = 1'b1;
        st_d.pf_code = 32'h0;
        st_d.pf_code[`TC_PF_ENCLAVE_BIT] = 1'b1;
      end
      track_check_pkg::OUT_EXIT:
      begin
        st_d.vm_exit = 1'b1;
        st_d.exit_gpa = I_ENCLAVE_CONTEXT;
      end
      track_check_pkg::OUT_DONE:
      begin
        st_d.done = 1'b1;
        st_d.arith_clr = 1'b1;
        // Flags follow the code so they can never disagree
        st_d.zf = (st_d.rax == `TC_RET_PAGE_CONFLICT) ||
          (st_d.rax == `TC_RET_PAGE_INVALID) || (st_d.rax == `TC_RET_PREV_INCOMPLETE);
        st_d.cf = (st_d.rax == `TC_RET_NOT_NEEDED);
      end
      default: ;
    endcase
    // Register port; events set sticky bits, set wins over clear
    events = 3'h0;
    events[`TC_EV_DONE] = st_d.done;
    events[`TC_EV_FAULT] = st_d.gp || st_d.pf || st_d.inv_op;
    events[`TC_EV_EXIT] = st_d.vm_exit;
    if (I_REG_WR)
    begin
      case (I_REG_ADDR)
        `TC_REG_CTRL: st_d.leaf_en = I_REG_WDATA[0];
        `TC_REG_IRQ_EN: st_d.irq_en = I_REG_WDATA[2:0];
        `TC_REG_IRQ_CLR: st_d.status = st_q.status & ~I_REG_WDATA[2:0];
        default: ;
      endcase
    end
    st_d.status = st_d.status | events;
    if (I_REG_RD)
    begin
      case (I_REG_ADDR)
        `TC_REG_CTRL: st_d.rdata = {31'h0, st_q.leaf_en};
        `TC_REG_STATUS: st_d.rdata = {29'h0, st_q.status};
        `TC_REG_IRQ_EN: st_d.rdata = {29'h0, st_q.irq_en};
        `TC_REG_LAST_RET: st_d.rdata = st_q.rax[31:0];
        `TC_REG_FEATURE: st_d.rdata = 32'h1 << `TC_FEATURE_BIT;
        default: st_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      st_q <= '0;
      st_q.leaf_en <= `TC_CTRL_RESET;
      st_q.irq_en <= `TC_IRQ_EN_RESET;
    end
    else
      st_q <= st_d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign O_REG_RDATA = st_q.rdata;
  assign O_DONE = st_q.done;
  assign O_RAX = st_q.rax;
  assign O_ZF = st_q.zf;
  assign O_CF = st_q.cf;
  assign O_ARITH_CLR = st_q.arith_clr;
  assign O_CTRL_PAGE = st_q.ctrl_page;
  assign O_TRACK_LOCK = st_q.track_lock;
  assign O_INV_OP = st_q.inv_op;
  assign O_GP_FAULT = st_q.gp;
  assign O_PG_FAULT = st_q.pf;
  assign O_PF_CODE = st_q.pf_code;
  assign O_VM_EXIT = st_q.vm_exit;
  assign O_EXIT_REASON = `TC_EXIT_REASON;
  assign O_EXIT_QUAL = st_q.exit_qual;
  assign O_EXIT_ERROR = 32'h0;
  assign O_EXIT_GPA = st_q.exit_gpa;
  assign O_EXIT_GLA = '0;
  assign O_IRQ = |(st_q.status & st_q.irq_en);

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  logic clean_req;
  assign clean_req = leaf_hit && I_CPL == `TC_CPL_SUPERVISOR && !I_PROT_MODE && !I_LONG_MODE;

  chk_leaf_select: assert property (
    I_REQ && I_EAX != `TC_LEAF_CODE |=> !O_DONE && !O_GP_FAULT && !O_PG_FAULT && !O_VM_EXIT)
    else $error("foreign leaf code produced an outcome");
  chk_cpl_gate: assert property (
    leaf_hit && I_CPL != `TC_CPL_SUPERVISOR |=> O_INV_OP && !O_DONE)
    else $error("leaf accepted above privilege zero");
  chk_align_fault: assert property (
    clean_req && I_RCX[11:0] != 12'h0 |=> O_GP_FAULT && !O_DONE)
    else $error("misaligned page without protection fault");
  chk_pf_enclave_bit: assert property (
    clean_req && I_RCX[11:0] == 12'h0 && !I_IN_PAGE_CACHE |=> O_PG_FAULT && O_PF_CODE[15])
    else $error("page fault missing or without enclave bit");
  chk_invalid_code: assert property (
    clean_req && I_RCX[11:0] == 12'h0 && I_IN_PAGE_CACHE && !I_PAGE_MODIFYING && !I_MAP_VALID
    |=> O_DONE && O_RAX == 64'h6 && O_ZF && !O_CF)
    else $error("invalid page result wrong");
  chk_not_needed: assert property (
    O_DONE && O_CF |-> O_RAX == 64'h1b && !O_ZF)
    else $error("carry without not-needed code");
  chk_conflict_flags: assert property (
    O_DONE && O_RAX == 64'h7 |-> O_ZF && !O_CF && !O_TRACK_LOCK)
    else $error("conflict code with wrong flags");
  chk_exit_fields: assert property (
    O_VM_EXIT |-> O_EXIT_GLA == '0 && O_EXIT_ERROR == 32'h0 && !O_DONE &&
    (O_EXIT_QUAL == `TC_QUAL_RESOURCE || O_EXIT_QUAL == `TC_QUAL_REFERENCE))
    else $error("exit fields malformed");
  chk_success_clear: assert property (
    O_DONE && O_RAX == 64'h0 |-> !O_ZF && !O_CF && O_TRACK_LOCK)
    else $error("success with a flag set");
  chk_arith_clear: assert property (
    O_DONE || O_ARITH_CLR |-> O_DONE && O_ARITH_CLR && !O_GP_FAULT && !O_PG_FAULT &&
    !O_INV_OP && !O_VM_EXIT)
    else $error("arithmetic flag clear not paired with a clean completion");
  chk_modify_conflict: assert property (
    clean_req && I_RCX[11:0] == 12'h0 && I_IN_PAGE_CACHE && I_PAGE_MODIFYING
    |=> O_DONE && O_RAX == 64'h7 && O_ZF && !O_CF && !O_TRACK_LOCK)
    else $error("page under modification without conflict result");
  chk_owner_select: assert property (
    clean_req && I_RCX[11:0] == 12'h0 && I_IN_PAGE_CACHE && !I_PAGE_MODIFYING &&
    I_MAP_VALID && I_MAP_TYPE == `TC_PT_REGULAR |=> O_CTRL_PAGE == $past(I_MAP_OWNER))
    else $error("regular page not resolved through its owner");
  chk_pending_code: assert property (
    clean_req && I_RCX[11:0] == 12'h0 && I_IN_PAGE_CACHE && !I_PAGE_MODIFYING &&
    I_MAP_VALID && I_MAP_TYPE == `TC_PT_CONTROL && !I_TRACK_IN_USE &&
    I_TRACK_PENDING != 64'h0 && !virt_exit
    |=> O_DONE && O_RAX == 64'h11 && O_ZF && !O_CF)
    else $error("pending tracking without incomplete result");
  chk_seg_fault: assert property (
    leaf_hit && I_CPL == `TC_CPL_SUPERVISOR && I_PROT_MODE &&
    (I_SEG_VIOLATION || I_SEG_UNUSABLE) |=> O_GP_FAULT && !O_DONE)
    else $error("segment problem without protection fault");
  chk_one_outcome: assert property (
    $onehot0({O_DONE, O_INV_OP, O_GP_FAULT, O_PG_FAULT, O_VM_EXIT}))
    else $error("more than one outcome in a cycle");

  cov_success: cover property (O_DONE && O_RAX == 64'h0);
  cov_exit: cover property (O_VM_EXIT);
  cov_pending: cover property (O_DONE && O_RAX == 64'h11);
  cov_irq: cover property (O_IRQ);

endmodule // track_check_leaf

// file: tb/page_lookup_model.sv
// Far-side page lookup model: residency, map entry and tracking state of a page.
// Assumes the bench encodes the page state in address bits 20:12.
`timescale 1ns/1ps
module page_lookup_model (
  // Page address
  input wire logic [63:0] i_rcx,
  // Lookup answers
  output logic o_in_cache,
  output logic o_modifying,
  output logic o_valid,
  output logic [7:0] o_type,
  output logic [63:0] o_owner,
  output logic o_track_in_use,
  output logic [63:0] o_pending,
  output logic [63:0] o_context
);
  // ****************************************
  // State decode
  // ****************************************
  // Pending is never a plain 1 so a check of bit 0 alone would be caught
  always_comb
  begin
    o_in_cache = !i_rcx[20];
    o_modifying = i_rcx[12];
    o_valid = !i_rcx[13];
    o_type = {5'h00, i_rcx[16:14]};
    o_owner = {i_rcx[63:21], 21'h0};
    o_track_in_use = i_rcx[17];
    o_pending = i_rcx[18] ? {i_rcx[63:12], 12'h100} : 64'h0;
    o_context = ~i_rcx;
  end
endmodule // page_lookup_model

// file: tb/testbench.sv
// Self-checking bench of the tracking check leaf: registers, directed and random requests.
// Assumes the lookup model answers from the page address bits.
`timescale 1ns/1ps
`include "track_check_map.svh"
module testbench;
  typedef struct packed {
    logic [2:0] k;
    logic [63:0] r;
    logic z;
    logic c;
    logic [7:0] q;
    logic [63:0] cp;
    logic ck;
    logic [63:0] g;
  } note_t;
  // Set before any process starts so no false falling edge is seen at time zero
  logic clk = 1'b0;
  logic rst_n, req, pm, lm, sv, su, vn, ve, rw, rr, rrd, en;
  logic ic, mo, va, tu, done, zf, cf, ac, tl, io, gp, pf, vx, irq;
  logic [1:0] cpl;
  logic [7:0] ra, ty, qual;
  logic [15:0] ers;
  logic [31:0] eax, wd, rd, pfc, eer;
  logic [63:0] rcx, own, pend, ctx, rax, cpg, gpa, gla, a, r;
  logic [63:0] seed = 64'h0000_0000_0001_39b8;
  logic [63:0] base = 64'h0000_0012_3400_0000;
  int err_count, comparisons, cyc;
  note_t notes[$];
  note_t m;
  logic [31:0] rq[$];
  logic [63:0] dv[16] = '{64'h1000, 64'h2000, 64'h3000, 64'h20000, 64'h20000, 64'h40000,
    64'h40000, 64'h60000, 64'h60000, 64'h100000, 64'h100001, 64'h0, 64'h0, 64'h0,
    64'h8000_0000_0000_0000, 64'h40000};
  logic [5:0] df[16] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h03, 6'h00, 6'h03, 6'h00, 6'h03,
    6'h00, 6'h00, 6'h28, 6'h24, 6'h0c, 6'h10, 6'h02};

  track_check_leaf dut_u (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_REQ(req), .I_EAX(eax),
    .I_RCX(rcx), .I_CPL(cpl), .I_PROT_MODE(pm), .I_LONG_MODE(lm), .I_SEG_VIOLATION(sv),
    .I_SEG_UNUSABLE(su), .I_VMX_NONROOT(vn), .I_EPC_VIRT_EN(ve), .I_IN_PAGE_CACHE(ic),
    .I_PAGE_MODIFYING(mo), .I_MAP_VALID(va), .I_MAP_TYPE(ty), .I_MAP_OWNER(own),
    .I_TRACK_IN_USE(tu), .I_TRACK_PENDING(pend), .I_ENCLAVE_CONTEXT(ctx), .I_REG_ADDR(ra),
    .I_REG_WDATA(wd), .I_REG_WR(rw), .I_REG_RD(rr), .O_REG_RDATA(rd), .O_DONE(done),
    .O_RAX(rax), .O_ZF(zf), .O_CF(cf), .O_ARITH_CLR(ac), .O_CTRL_PAGE(cpg),
    .O_TRACK_LOCK(tl), .O_INV_OP(io), .O_GP_FAULT(gp), .O_PG_FAULT(pf), .O_PF_CODE(pfc),
    .O_VM_EXIT(vx), .O_EXIT_REASON(ers), .O_EXIT_QUAL(qual), .O_EXIT_ERROR(eer),
    .O_EXIT_GPA(gpa), .O_EXIT_GLA(gla), .O_IRQ(irq));
  page_lookup_model far_u (.i_rcx(rcx), .o_in_cache(ic), .o_modifying(mo), .o_valid(va),
    .o_type(ty), .o_owner(own), .o_track_in_use(tu), .o_pending(pend), .o_context(ctx));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [63:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 7);
    seed = seed ^ (seed << 17);
    return seed;
  endfunction

  // f holds protected, long, seg violation, seg unusable, non-root, virt enable
  function automatic note_t exp_of(logic [1:0] c, logic [63:0] a, logic [5:0] f);
    note_t n;
    logic x;
    n = '0;
    x = &f[1:0];
    n.k = track_check_pkg::OUT_DONE;
    n.z = 1'b1;
    n.ck = 1'b1;
    n.g = ~a;
    n.cp = (a[16:14] == 3'h0) ? a : {a[63:21], 21'h0};
    if (c != `TC_CPL_SUPERVISOR) n.k = track_check_pkg::OUT_INV_OP;
    else if (f[5] && |f[3:2]) n.k = track_check_pkg::OUT_GP;
    else if (f[4] && a[63:47] != {17{a[47]}}) n.k = track_check_pkg::OUT_GP;
    else if (a[11:0] != 12'h000) n.k = track_check_pkg::OUT_GP;
    else if (a[20]) n.k = track_check_pkg::OUT_PF;
    else if (a[12]) {n.r, n.ck} = {`TC_RET_PAGE_CONFLICT, 1'b0};
    else if (a[13]) {n.r, n.ck} = {`TC_RET_PAGE_INVALID, 1'b0};
    else if (a[16:14] > 3'h5) {n.r, n.z, n.c, n.ck} = {`TC_RET_NOT_NEEDED, 3'b010};
    else if (a[17] && x) {n.k, n.q} = {track_check_pkg::OUT_EXIT, `TC_QUAL_RESOURCE};
    else if (a[17]) n.r = `TC_RET_PAGE_CONFLICT;
    else if (a[18] && x) {n.k, n.q} = {track_check_pkg::OUT_EXIT, `TC_QUAL_REFERENCE};
    else if (a[18]) n.r = `TC_RET_PREV_INCOMPLETE;
    else n.z = 1'b0;
    return n;
  endfunction

  task automatic chk(logic [191:0] s, logic [191:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic leaf(logic [31:0] e, logic [1:0] c, logic [63:0] a, logic [5:0] f);
    @(posedge clk);
    {req, eax, cpl, rcx} <= {1'b1, e, c, a};
    {pm, lm, sv, su, vn, ve} <= f;
    if (e == `TC_LEAF_CODE && en) notes.push_back(exp_of(c, a, f));
  endtask

  task automatic idle();
    @(posedge clk);
    req <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic wr(logic [7:0] ad, logic [31:0] d);
    @(posedge clk);
    {rw, ra, wd} <= {1'b1, ad, d};
    @(posedge clk);
    rw <= 1'b0;
  endtask

  task automatic rdx(logic [7:0] ad, logic [31:0] e);
    @(posedge clk);
    {rr, ra} <= {1'b1, ad};
    rq.push_back(e);
    @(posedge clk);
    rr <= 1'b0;
  endtask

  task automatic see(logic v);
    repeat (2) @(negedge clk);
    chk(irq, v);
  endtask

  task automatic close_out();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************
  // Monitor and timeout
  // ****************************************
  // Falling edge sampling keeps registered results clear of the launching edge
  always @(negedge clk)
  begin
    if (rrd) chk(rd, rq.pop_front());
    else chk(rd, 32'h0);
    rrd = rr;
    if (rst_n && (done | io | gp | pf | vx))
    begin
      if (notes.size() == 0) chk(1'b1, 1'b0);
      else
      begin
        m = notes.pop_front();
        chk({done, vx, pf, gp, io}, 5'h01 << (m.k - 3'h1));
        chk(ac, done);
        if (done) chk({rax, zf, cf, tl}, {m.r, m.z, m.c, m.r == 64'h0});
        if ((done | vx) && m.ck) chk(cpg, m.cp);
        if (pf) chk(pfc[`TC_PF_ENCLAVE_BIT], 1'b1);
        if (vx) chk({ers, qual, eer, gpa, gla}, {`TC_EXIT_REASON, m.q, 32'h0, m.g, 64'h0});
      end
    end
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      close_out();
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rst_n, req, eax, cpl, rcx, pm, lm, sv, su, vn, ve, ra, wd, rw, rr, rrd} = '0;
    en = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdx(`TC_REG_CTRL, {31'h0, `TC_CTRL_RESET});
    rdx(`TC_REG_IRQ_EN, 32'h0);
    rdx(`TC_REG_STATUS, 32'h0);
    rdx(`TC_REG_FEATURE, 32'h1 << `TC_FEATURE_BIT);
    rdx(8'hf0, 32'h0);
    wr(`TC_REG_IRQ_EN, 32'h7);
    leaf(`TC_LEAF_CODE, 2'h0, base, 6'h00);
    idle();
    see(1'b1);
    wr(`TC_REG_IRQ_CLR, 32'h1);
    see(1'b0);
    leaf(`TC_LEAF_CODE, 2'h3, base + 64'h1, 6'h00);
    idle();
    see(1'b1);
    rdx(`TC_REG_STATUS, 32'h2);
    wr(`TC_REG_IRQ_EN, 32'h0);
    see(1'b0);
    wr(`TC_REG_IRQ_CLR, 32'h7);
    rdx(`TC_REG_STATUS, 32'h0);
    wr(`TC_REG_CTRL, 32'h0);
    en = 1'b0;
    leaf(`TC_LEAF_CODE, 2'h0, base, 6'h00);
    idle();
    wr(`TC_REG_CTRL, 32'h1);
    en = 1'b1;
    leaf(32'h0000_000c, 2'h0, base, 6'h00);
    idle();
    $display("test registers done");
    for (int i = 0; i < 8; i++)
      leaf(`TC_LEAF_CODE, 2'h0, base | (64'(i) << 14), 6'h00);
    foreach (dv[i])
      leaf(`TC_LEAF_CODE, 2'h0, base ^ dv[i], df[i]);
    idle();
    rdx(`TC_REG_LAST_RET, 32'h11);
    $display("test directed done");
    // Failure bits are ANDed so more random requests reach the later checks
    repeat (300)
    begin
      r = rnd();
      a = {{17{r[47]}}, r[46:21], r[20:12] & r[38:30], (r[50:48] == 3'h0) ? r[11:0] : 12'h000};
      a[62] = a[62] ^ (r[53:51] == 3'h0);
      leaf(`TC_LEAF_CODE, (r[63:61] == 3'h0) ? r[1:0] : 2'h0, a,
        {r[59:58], r[57:56] & r[61:60], r[55:54]});
    end
    idle();
    repeat (2) @(negedge clk);
    chk(notes.size(), 0);
    $display("test random done");
    close_out();
  end
endmodule // testbench
